//--- rtl/fsiom_consts.svh
// offsets, field positions, reset-free constants and timing counts of the io mapping block
`ifndef FSIOM_CONSTS_SVH
`define FSIOM_CONSTS_SVH

`define FSIOM_ADDR_W 8
`define FSIOM_CTRL_OFS 8'h00
`define FSIOM_SOFT_OFS 8'h04
`define FSIOM_LEN1_OFS 8'h08
`define FSIOM_LEN2_OFS 8'h0c
`define FSIOM_STAT_OFS 8'h10
`define FSIOM_MAP1_OFS 8'h14
`define FSIOM_MAP2_OFS 8'h18

`define FSIOM_CTRL_V2_BIT 0
`define FSIOM_CTRL_RESTART_BIT 1
`define FSIOM_SOFT_RATE_LSB 8

`define FSIOM_RESP_OKAY 2'b00
`define FSIOM_RESP_SLVERR 2'b10

`define FSIOM_DIGIT_MAX 4'h9
`define FSIOM_SOFT_SEL 4'h9
`define FSIOM_DIGIT_WEIGHT 8'd10
`define FSIOM_STATION_MIN 8'd1
`define FSIOM_STATION_MAX 8'd64
`define FSIOM_RATE_MAX 4'h4
`define FSIOM_SOFT_RATE_MAX 3'h4

`define FSIOM_LEN_CAP 8'd200
`define FSIOM_V1_STEP 8'd12
`define FSIOM_V1_BITS_PER_STN 8'd4
`define FSIOM_V1_NOWORD_LEN 8'd4
`define FSIOM_V1_MAX_LEN 8'd48
`define FSIOM_V1_MAX_STN 3'd4
`define FSIOM_V1_MAX_BITS 8'd16
`define FSIOM_V1_MAX_WORDS 9'd32

`define FSIOM_V2_ENTRIES 16
`define FSIOM_V2_STN_PER_ROW 4
`define FSIOM_V2_LEN_TAB {9'd368, 9'd272, 9'd176, 9'd80, 9'd184, 9'd136, 9'd88, 9'd40, \
    9'd92, 9'd68, 9'd44, 9'd20, 9'd48, 9'd36, 9'd24, 9'd12}
`define FSIOM_V2_BIT_TAB {8'd112, 8'd80, 8'd48, 8'd16, 8'd56, 8'd40, 8'd24, 8'd8, \
    8'd28, 8'd20, 8'd12, 8'd4, 8'd16, 8'd12, 8'd8, 8'd4}

`define FSIOM_SETTLE_CYC 4'd3

`endif

//--- rtl/fsiom_pkg.sv
// types shared by the io mapping block
package fsiom_pkg;

    typedef enum logic [2:0] {FSIOM_BAUD_156K, FSIOM_BAUD_625K, FSIOM_BAUD_2M5, FSIOM_BAUD_5M,
        FSIOM_BAUD_10M} fsiom_baud_t;

    typedef enum logic {FSIOM_SETTLE, FSIOM_RUN} fsiom_phase_t;

    typedef struct packed {
        logic [2:0] stations;
        logic [3:0] cycles;
        logic [7:0] bit_bytes;
        logic [8:0] word_bytes;
    } fsiom_map_t;

    typedef struct packed {
        fsiom_phase_t phase;
        logic [3:0] settle;
        logic aw_rdy;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_rdy;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic version2;
        logic [6:0] soft_station;
        logic [2:0] soft_rate;
        logic [7:0] len_first;
        logic [7:0] len_second;
        logic [6:0] station;
        fsiom_baud_t rate;
        logic station_err;
        logic rate_err;
        logic soft_station_used;
        logic soft_rate_used;
        fsiom_map_t map_first;
        fsiom_map_t map_second;
        logic len_err;
        logic run;
        logic err;
        logic rd;
        logic sd;
        logic [2:0] occupied;
    } fsiom_state_t;

endpackage : fsiom_pkg

//--- rtl/fsiom_sync.sv
// two-flop synchroniser for the rotary switch pins
`timescale 1ns/10ps
module fsiom_sync #(
    parameter int WIDTH = 12
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } fsiom_sync_state_t;

    fsiom_sync_state_t st_ff;
    fsiom_sync_state_t nxt_st;

    // the meta stage feeds only the second stage
    always_comb
    begin
        nxt_st.meta = async_i;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign sync_o = st_ff.sync;
endmodule : fsiom_sync

//--- rtl/fsiom_v2_match.sv
// matches a data length against the extended-cycle size table
`timescale 1ns/10ps
`include "fsiom_consts.svh"
module fsiom_v2_match
    import fsiom_pkg::*;
#(
    parameter int ENTRIES = `FSIOM_V2_ENTRIES
) (
    input wire logic [7:0] len_i,
    output logic hit_o,
    output fsiom_map_t map_o
);
    localparam logic [ENTRIES*9-1:0] LEN_TAB = `FSIOM_V2_LEN_TAB;
    localparam logic [ENTRIES*8-1:0] BIT_TAB = `FSIOM_V2_BIT_TAB;

    logic [ENTRIES-1:0] hit;

    // entry index is cycle code times four plus stations minus one
    for (genvar i = 0; i < ENTRIES; i++)
    begin : g_entry
        assign hit[i] = ({1'b0, len_i} == LEN_TAB[i*9 +: 9]);
    end

    // table lengths are unique, so at most one entry hits
    always_comb
    begin
        map_o = '0;
        hit_o = |hit;
        for (int j = 0; j < ENTRIES; j++)
        begin
            if (hit[j])
            begin
                map_o.stations = 3'((j % `FSIOM_V2_STN_PER_ROW) + 1);
                map_o.cycles = 4'(1 << (j / `FSIOM_V2_STN_PER_ROW));
                map_o.bit_bytes = BIT_TAB[j*8 +: 8];
                map_o.word_bytes = LEN_TAB[j*9 +: 9] - {1'b0, BIT_TAB[j*8 +: 8]};
            end
        end
    end
endmodule : fsiom_v2_match

//--- rtl/fsiom_top.sv
// station, baud and cyclic data mapping logic with an axi4-lite register slave
//
// How it works
// - run indicator green only when participating, no timeout
// - error indicator red on crc, station, baud faults
// - station equals tens digit times ten plus ones
// - switches at 99 take software station number
// - station captured only at start-up or restart
// - rate switch 0-4 decode; 9 selects software rate
// - version 1 stations from length in twelves
// - version 1 bit bytes four per station
// - version 1 above 48 exposes 16+32 bytes
// - configured lengths capped at 200 bytes
// - data split into bit and word areas
// - version 2 up to 4 stations, 8 cycles
// - version 2 sizes from station and cycle table
// - version 2 unmatched length raises configuration error
`timescale 1ns/10ps
`include "fsiom_consts.svh"
module fsiom_top
    import fsiom_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] station_tens_switch_i,
    input wire logic [3:0] station_ones_switch_i,
    input wire logic [3:0] rate_select_switch_i,
    input wire logic net_participating_i,
    input wire logic net_timeout_i,
    input wire logic crc_error_i,
    input wire logic baud_mismatch_i,
    input wire logic rx_active_i,
    input wire logic tx_active_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic run_indicator_o,
    output logic error_indicator_o,
    output logic receive_activity_indicator_o,
    output logic send_activity_indicator_o,
    output logic [6:0] station_number_o,
    output fsiom_baud_t baud_code_o,
    output logic config_error_o,
    output logic [2:0] occupied_stations_o
);
    fsiom_state_t st_ff;
    fsiom_state_t nxt_st;

    logic [11:0] sw_sync;
    logic [3:0] tens_sw;
    logic [3:0] ones_sw;
    logic [3:0] rate_sw;
    logic [7:0] sw_sum;
    logic [6:0] sw_station;
    logic sw_soft_station;
    logic capture_now;
    logic run_cause;
    logic err_cause;
    logic v2_hit_first;
    logic v2_hit_second;
    fsiom_map_t v2_map_first;
    fsiom_map_t v2_map_second;

    fsiom_sync #(
        .WIDTH(12)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i({rate_select_switch_i, station_tens_switch_i, station_ones_switch_i}),
        .sync_o(sw_sync)
    );

    fsiom_v2_match u_match_first (
        .len_i(st_ff.len_first),
        .hit_o(v2_hit_first),
        .map_o(v2_map_first)
    );

    fsiom_v2_match u_match_second (
        .len_i(st_ff.len_second),
        .hit_o(v2_hit_second),
        .map_o(v2_map_second)
    );

    assign rate_sw = sw_sync[11:8];
    assign tens_sw = sw_sync[7:4];
    assign ones_sw = sw_sync[3:0];
    assign sw_sum = 8'({4'h0, tens_sw} * `FSIOM_DIGIT_WEIGHT) + {4'h0, ones_sw};
    assign sw_station = sw_sum[6:0];
    assign sw_soft_station = (tens_sw == `FSIOM_SOFT_SEL) && (ones_sw == `FSIOM_SOFT_SEL);
    // settle lets the synchroniser fill before the one-time sample
    assign capture_now = (st_ff.phase == FSIOM_SETTLE) && (st_ff.settle == `FSIOM_SETTLE_CYC);
    assign run_cause = net_participating_i && !net_timeout_i;
    assign err_cause = crc_error_i || baud_mismatch_i || st_ff.station_err || st_ff.rate_err;

    // lengths of 4 or less still occupy one station with its 4 bit bytes
    function automatic fsiom_map_t map_v1(input logic [7:0] len);
        fsiom_map_t m;
        m = '0;
        m.cycles = 4'h1;
        if (len > `FSIOM_V1_MAX_LEN)
        begin
            m.stations = `FSIOM_V1_MAX_STN;
            m.bit_bytes = `FSIOM_V1_MAX_BITS;
            m.word_bytes = `FSIOM_V1_MAX_WORDS;
        end
        else if (len <= `FSIOM_V1_NOWORD_LEN)
        begin
            m.stations = 3'd1;
            m.bit_bytes = `FSIOM_V1_BITS_PER_STN;
            m.word_bytes = 9'd0;
        end
        else
        begin
            m.stations = 3'((len + `FSIOM_V1_STEP - 8'd1) / `FSIOM_V1_STEP);
            m.bit_bytes = 8'({5'h0, m.stations} * `FSIOM_V1_BITS_PER_STN);
            m.word_bytes = {1'b0, len - m.bit_bytes};
        end
        return m;
    endfunction : map_v1

    function automatic logic [7:0] clamp_len(input logic [15:0] v);
        return (v > {8'h00, `FSIOM_LEN_CAP}) ? `FSIOM_LEN_CAP : v[7:0];
    endfunction : clamp_len

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.run = run_cause;
        nxt_st.err = err_cause;
        nxt_st.rd = rx_active_i;
        nxt_st.sd = tx_active_i;
        unique case (st_ff.phase)
            FSIOM_SETTLE:
            begin
                if (capture_now)
                begin
                    nxt_st.phase = FSIOM_RUN;
                    nxt_st.soft_station_used = sw_soft_station;
                    if (sw_soft_station)
                    begin
                        nxt_st.station = st_ff.soft_station;
                        nxt_st.station_err = ({1'b0, st_ff.soft_station} < `FSIOM_STATION_MIN) ||
                            ({1'b0, st_ff.soft_station} > `FSIOM_STATION_MAX);
                    end
                    else
                    begin
                        nxt_st.station = sw_station;
                        nxt_st.station_err = (sw_sum < `FSIOM_STATION_MIN) || (sw_sum > `FSIOM_STATION_MAX) ||
                            (tens_sw > `FSIOM_DIGIT_MAX) || (ones_sw > `FSIOM_DIGIT_MAX);
                    end
                    nxt_st.soft_rate_used = (rate_sw == `FSIOM_SOFT_SEL);
                    if (rate_sw == `FSIOM_SOFT_SEL)
                    begin
                        nxt_st.rate = fsiom_baud_t'(st_ff.soft_rate);
                        nxt_st.rate_err = (st_ff.soft_rate > `FSIOM_SOFT_RATE_MAX);
                    end
                    else if (rate_sw <= `FSIOM_RATE_MAX)
                    begin
                        nxt_st.rate = fsiom_baud_t'(rate_sw[2:0]);
                        nxt_st.rate_err = 1'b0;
                    end
                    else
                    begin
                        nxt_st.rate = FSIOM_BAUD_156K;
                        nxt_st.rate_err = 1'b1;
                    end
                end
                else
                begin
                    nxt_st.settle = st_ff.settle + 4'h1;
                end
            end
            FSIOM_RUN:
            begin
                nxt_st.settle = st_ff.settle;
            end
        endcase
        // mapping follows the length registers live; version 2 uses the table
        nxt_st.map_first = st_ff.version2 ? v2_map_first : map_v1(st_ff.len_first);
        nxt_st.map_second = st_ff.version2 ? v2_map_second : map_v1(st_ff.len_second);
        nxt_st.len_err = st_ff.version2 && !(v2_hit_first && v2_hit_second);
        nxt_st.occupied = (nxt_st.map_first.stations > nxt_st.map_second.stations) ?
            nxt_st.map_first.stations : nxt_st.map_second.stations;
        // write channel: address and data taken in either order
        if (st_ff.bvalid && s_axi_bready_i)
            nxt_st.bvalid = 1'b0;
        if (s_axi_awvalid_i && st_ff.aw_rdy)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st_ff.w_rdy)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata_i;
            nxt_st.w_strb = s_axi_wstrb_i;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `FSIOM_RESP_OKAY;
            case (st_ff.aw_addr)
                `FSIOM_CTRL_OFS:
                begin
                    if (st_ff.w_strb[0])
                    begin
                        nxt_st.version2 = st_ff.w_data[`FSIOM_CTRL_V2_BIT];
                        // a restart resamples the switches, as a reboot would
                        if (st_ff.w_data[`FSIOM_CTRL_RESTART_BIT])
                        begin
                            nxt_st.phase = FSIOM_SETTLE;
                            nxt_st.settle = 4'h0;
                        end
                    end
                end
                `FSIOM_SOFT_OFS:
                begin
                    if (st_ff.w_strb[0])
                        nxt_st.soft_station = st_ff.w_data[6:0];
                    if (st_ff.w_strb[1])
                        nxt_st.soft_rate = st_ff.w_data[`FSIOM_SOFT_RATE_LSB +: 3];
                end
                `FSIOM_LEN1_OFS:
                begin
                    if (st_ff.w_strb[0])
                        nxt_st.len_first = clamp_len({st_ff.w_strb[1] ? st_ff.w_data[15:8] : 8'h00,
                            st_ff.w_data[7:0]});
                end
                `FSIOM_LEN2_OFS:
                begin
                    if (st_ff.w_strb[0])
                        nxt_st.len_second = clamp_len({st_ff.w_strb[1] ? st_ff.w_data[15:8] : 8'h00,
                            st_ff.w_data[7:0]});
                end
                `FSIOM_STAT_OFS, `FSIOM_MAP1_OFS, `FSIOM_MAP2_OFS:
                begin
                    nxt_st.bresp = `FSIOM_RESP_OKAY;
                end
                default:
                begin
                    nxt_st.bresp = `FSIOM_RESP_SLVERR;
                end
            endcase
        end
        // read channel
        if (st_ff.rvalid && s_axi_rready_i)
            nxt_st.rvalid = 1'b0;
        if (s_axi_arvalid_i && st_ff.ar_rdy)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `FSIOM_RESP_OKAY;
            case (s_axi_araddr_i)
                `FSIOM_CTRL_OFS: nxt_st.rdata = {31'h0, st_ff.version2};
                `FSIOM_SOFT_OFS: nxt_st.rdata = {21'h0, st_ff.soft_rate, 1'b0, st_ff.soft_station};
                `FSIOM_LEN1_OFS: nxt_st.rdata = {24'h0, st_ff.len_first};
                `FSIOM_LEN2_OFS: nxt_st.rdata = {24'h0, st_ff.len_second};
                `FSIOM_STAT_OFS: nxt_st.rdata = {11'h0, st_ff.soft_rate_used, st_ff.soft_station_used,
                    st_ff.len_err, st_ff.rate_err, st_ff.station_err, 5'h0, st_ff.rate, 1'b0, st_ff.station};
                `FSIOM_MAP1_OFS: nxt_st.rdata = {7'h0, st_ff.map_first.word_bytes, st_ff.map_first.bit_bytes,
                    st_ff.map_first.cycles, 1'b0, st_ff.map_first.stations};
                `FSIOM_MAP2_OFS: nxt_st.rdata = {7'h0, st_ff.map_second.word_bytes, st_ff.map_second.bit_bytes,
                    st_ff.map_second.cycles, 1'b0, st_ff.map_second.stations};
                default:
                begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = `FSIOM_RESP_SLVERR;
                end
            endcase
        end
        // one write and one read in flight; readies drop while a response waits
        nxt_st.aw_rdy = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.w_rdy = !nxt_st.w_got && !nxt_st.bvalid;
        nxt_st.ar_rdy = !nxt_st.rvalid;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign s_axi_awready_o = st_ff.aw_rdy;
    assign s_axi_wready_o = st_ff.w_rdy;
    assign s_axi_bresp_o = st_ff.bresp;
    assign s_axi_bvalid_o = st_ff.bvalid;
    assign s_axi_arready_o = st_ff.ar_rdy;
    assign s_axi_rdata_o = st_ff.rdata;
    assign s_axi_rresp_o = st_ff.rresp;
    assign s_axi_rvalid_o = st_ff.rvalid;
    assign run_indicator_o = st_ff.run;
    assign error_indicator_o = st_ff.err;
    assign receive_activity_indicator_o = st_ff.rd;
    assign send_activity_indicator_o = st_ff.sd;
    assign station_number_o = st_ff.station;
    assign baud_code_o = st_ff.rate;
    assign config_error_o = st_ff.len_err;
    assign occupied_stations_o = st_ff.occupied;

    run_led_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> run_indicator_o == $past(run_cause)) else $error("run indicator wrong");
    err_led_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> error_indicator_o == $past(err_cause)) else $error("error indicator wrong");
    activity_led_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rx_active_i && !tx_active_i |=> receive_activity_indicator_o && !send_activity_indicator_o)
        else $error("activity indicators wrong");
    station_sum_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        capture_now && !sw_soft_station |=> station_number_o == $past(sw_station))
        else $error("switch station number wrong");
    station_soft_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        capture_now && sw_soft_station |=> station_number_o == $past(st_ff.soft_station))
        else $error("software station number not used");
    station_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_ff.phase == FSIOM_RUN) ##1 (st_ff.phase == FSIOM_RUN) |-> $stable(station_number_o))
        else $error("station number changed while running");
    rate_decode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        capture_now && (rate_sw == 4'h3) |=> (baud_code_o == FSIOM_BAUD_5M) && !st_ff.rate_err)
        else $error("rate switch decode wrong");
    v1_stations_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!st_ff.version2 && st_ff.len_first > 8'd24 && st_ff.len_first <= 8'd36) ##1
        ($stable(st_ff.len_first) && !st_ff.version2) |-> st_ff.map_first.stations == 3'd3)
        else $error("version 1 station count wrong");
    v1_words_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!st_ff.version2 && st_ff.len_first > 8'd4 && st_ff.len_first <= 8'd48) ##1
        ($stable(st_ff.len_first) && !st_ff.version2) |->
        ({1'b0, st_ff.len_first} == {1'b0, st_ff.map_first.bit_bytes} + st_ff.map_first.word_bytes))
        else $error("version 1 word bytes wrong");
    v1_over48_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!st_ff.version2 && st_ff.len_first > 8'd48) ##1 ($stable(st_ff.len_first) && !st_ff.version2)
        |-> st_ff.map_first.bit_bytes == 8'd16 && st_ff.map_first.word_bytes == 9'd32)
        else $error("version 1 large length mapping wrong");
    len_cap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_ff.len_first <= 8'd200 && st_ff.len_second <= 8'd200) else $error("length above cap");
    v2_size_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_ff.version2 && st_ff.len_first == 8'd12) ##1 ($stable(st_ff.len_first) && st_ff.version2) |->
        st_ff.map_first.stations == 3'd1 && st_ff.map_first.cycles == 4'd1 &&
        st_ff.map_first.bit_bytes == 8'd4 && st_ff.map_first.word_bytes == 9'd8)
        else $error("version 2 size mapping wrong");
    v2_error_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_ff.version2 && st_ff.len_first == 8'd13) ##1 ($stable(st_ff.len_first) && st_ff.version2)
        |=> config_error_o) else $error("version 2 length error not raised");
endmodule : fsiom_top

//--- tb/fsiom_link_model.sv
// link-side model: network status and bus activity seen by the mapping block
`timescale 1ns/10ps
module fsiom_link_model (
    input wire logic ref_clk_i,
    input wire logic [5:0] cmd_i,
    output logic [5:0] ev_o
);
    // registered, so the block never sees a change in the edge's own time step
    always_ff @(posedge ref_clk_i)
        ev_o <= cmd_i;
endmodule : fsiom_link_model

//--- tb/fsiom_top_tb.sv
// self-checking bench of the io mapping block
`timescale 1ns/10ps
module fsiom_top_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] tens = 4'h5, ones = 4'h2, rsw = 4'h2;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdat;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [5:0] cmd = 6'h00;
    logic [5:0] ev;
    logic awr, wrdy, bv, arr, rv, run, errl, rdl, sdl, cfg;
    logic [1:0] br, rr;
    logic [6:0] stn;
    logic [2:0] baud, occ;
    int n_fail = 0, total_checks = 0;
    // ctrl, length, expected map word, occupied, config error
    localparam logic [55:0] ROWS [15] = '{
        56'h00_04_00000411_1_0, 56'h00_05_00010411_1_0, 56'h00_0c_00080411_1_0, 56'h00_0d_00050812_2_0,
        56'h00_24_00180c13_3_0, 56'h00_30_00201014_4_0, 56'h00_31_00201014_4_0, 56'h00_ff_00201014_4_0,
        56'h01_0c_00080411_1_0, 56'h01_14_00100421_1_0, 56'h01_b8_00803844_4_0, 56'h01_b0_00803082_2_0,
        56'h01_50_00401081_1_0, 56'h01_0d_00000000_1_1, 56'h01_ff_00000000_1_1};
    always #25 ref_clk_i = ~ref_clk_i;
    fsiom_link_model u_link (.ref_clk_i(ref_clk_i), .cmd_i(cmd), .ev_o(ev));
    fsiom_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .station_tens_switch_i(tens),
        .station_ones_switch_i(ones), .rate_select_switch_i(rsw), .net_participating_i(ev[0]),
        .net_timeout_i(ev[1]), .crc_error_i(ev[2]), .baud_mismatch_i(ev[3]), .rx_active_i(ev[4]),
        .tx_active_i(ev[5]), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .run_indicator_o(run), .error_indicator_o(errl),
        .receive_activity_indicator_o(rdl), .send_activity_indicator_o(sdl), .station_number_o(stn),
        .baud_code_o(baud), .config_error_o(cfg), .occupied_stations_o(occ));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            n++;
        end
        while (bv !== 1'b1 && n < 50);
        r = br;
        bready <= 1'b0;
        if (n >= 50)
        begin
            n_fail++;
            conclude();
        end
        else
            @(posedge ref_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (arv && arr) arv <= 1'b0;
            n++;
        end
        while (rv !== 1'b1 && n < 50);
        d = rdat;
        r = rr;
        rready <= 1'b0;
        if (n >= 50)
        begin
            n_fail++;
            conclude();
        end
        else
            @(posedge ref_clk_i);
    endtask : rd
    // restart resamples the switches; wait covers the synchroniser and settle count
    task automatic restart();
        logic [1:0] r;
        wr(8'h00, 32'h2, r);
        tick(10);
    endtask : restart
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        tick(4);
        rst_i <= 1'b0;
        tick(10);
        wr(8'h0c, 32'h0c, r);
        foreach (ROWS[i])
        begin
            wr(8'h00, {24'h0, ROWS[i][55:48]}, r);
            wr(8'h08, {24'h0, ROWS[i][47:40]}, r);
            rd(8'h14, d, r);
            chk(d, ROWS[i][39:8]);
            chk({29'h0, occ}, {28'h0, ROWS[i][7:4]});
            chk({31'h0, cfg}, {28'h0, ROWS[i][3:0]});
        end
        rd(8'h08, d, r);
        chk(d, 32'hc8);
        chk({25'h0, stn}, 32'h34);
        tens <= 4'h1;
        tick(10);
        chk({25'h0, stn}, 32'h34);
        for (int k = 0; k < 5; k++)
        begin
            rsw <= 4'(k);
            restart();
            chk({29'h0, baud}, 32'(k));
        end
        chk({25'h0, stn}, 32'h0c);
        wr(8'h04, 32'h0307, r);
        {tens, ones, rsw} <= 12'h999;
        restart();
        chk({22'h0, baud, stn}, 32'h187);
        for (int k = 0; k < 6; k++)
        begin
            cmd <= 6'h01 | 6'(1 << k);
            tick(3);
            chk({28'h0, run, errl, rdl, sdl}, {28'h0, k != 1, k == 2 || k == 3, k == 4, k == 5});
        end
        cmd <= 6'h00;
        rd(8'h20, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, 32'h2);
        wr(8'h1c, 32'h1, r);
        chk({30'h0, r}, 32'h2);
        {tens, ones, rsw} <= 12'h655;
        restart();
        chk({24'h0, errl, stn}, 32'hc1);
        {tens, ones, rsw} <= 12'h522;
        rst_i <= 1'b1;
        tick(2);
        chk({25'h0, stn}, 32'h0);
        rst_i <= 1'b0;
        tick(10);
        chk({22'h0, baud, stn}, 32'h134);
        conclude();
    end
endmodule : fsiom_top_tb
